// *** src/mjsr_map.svh ***
`ifndef MJSR_MAP_SVH
`define MJSR_MAP_SVH

// ----------------------------------------
// register sizes
// ----------------------------------------
`define MJSR_IR_W 8
`define MJSR_ID_W 32
`define MJSR_BSR_W 135
`define MJSR_MR_W 12
`define MJSR_MR2_W 10

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define MJSR_OP_EXTEST 8'h00
`define MJSR_OP_IDCODE 8'h21
`define MJSR_OP_SAMPLE 8'h05
`define MJSR_OP_CLAMP 8'h07
`define MJSR_OP_HIGHZ 8'h03
`define MJSR_OP_MODE01 8'h25
`define MJSR_OP_MODE2 8'h29
`define MJSR_OP_BYPASS 8'hff
// fixed pattern loaded into the instruction shifter on capture
`define MJSR_IR_CAPT 8'h01

// ----------------------------------------
// readout field positions
// ----------------------------------------
`define MJSR_M1_LSB 17
`define MJSR_M0_LSB 1
`define MJSR_RPR_BIT 13
`define MJSR_M2_LSB 1

// ----------------------------------------
// buffering
// ----------------------------------------
`define MJSR_FIFO_DEPTH 16

`endif

// *** src/mjsr_pkg.sv ***
package mjsr_pkg;
    // scan path selected by the current instruction
    typedef enum logic [1:0] {
        mjsr_path_byp = 2'b00,
        mjsr_path_id = 2'b01,
        mjsr_path_bsr = 2'b10
    } mjsr_path_type;

    // which mode register a queued word updates
    typedef enum logic [1:0] {
        mjsr_sel_zero = 2'b00,
        mjsr_sel_one = 2'b01,
        mjsr_sel_two = 2'b10
    } mjsr_mode_sel_type;
endpackage

// *** src/mjsr_sync.sv ***
// two flip-flop synchroniser for pins from outside the clock domain
module mjsr_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// *** src/mjsr_fifo.sv ***
// small flop fifo; ready is registered so it can leave the block directly
module mjsr_fifo #(
    parameter int W = 14,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];

    // pointers and occupancy
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            cnt <= next_cnt;
            in_ready_o <= (next_cnt != (AW+1)'(DEPTH));
        end
    end

    // storage needs no reset, only valid entries are ever read
    always_ff @(posedge clock_i) begin
        if (push) mem[wp] <= in_data_i;
    end
endmodule

// *** src/mjsr_scan_top.sv ***
`include "mjsr_map.svh"

// What this block does
// R1: 8-bit ir, bypass, 32-bit id, 135-cell chain
// R2: extest/sample capture ring, route boundary chain
// R3: idcode loads identification word into path
// R4: clamp: bypass path, balls from chain
// R5: highz: bypass path, all outputs tristated
// R6: mode01 loads mode registers zero, one
// R7: mode2 loads mode register two
// R8: bypass code selects one-bit bypass
// R9: id fields revision, device, vendor, one
// R10: mode01 layout, zero gaps, bit0 one
// R11: bit 13 shows repair capability
// R12: mode2 bits 10:1, bit0 one
// R13: undefined codes select the bypass path
// R14: sample captures ring on tck rise
// R15: reset selects idcode, releases outputs
// R16: lsb-first shift, ir changes on update
module mjsr_scan_top #(
    parameter logic [3:0] REVISION = 4'h0, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5a3c, // arbitrary value
    parameter logic [10:0] VENDOR_CODE = 11'h2b1, // arbitrary value
    parameter logic REPAIR_CAPABLE = 1'b0,
    parameter int FIFO_DEPTH = `MJSR_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic tlr_i,
    input wire logic capture_dr_i,
    input wire logic shift_dr_i,
    input wire logic update_dr_i,
    input wire logic capture_ir_i,
    input wire logic shift_ir_i,
    input wire logic update_ir_i,
    input wire logic [`MJSR_BSR_W-1:0] ring_i,
    input wire logic mode_valid_i,
    input wire logic [1:0] mode_sel_i,
    input wire logic [`MJSR_MR_W-1:0] mode_data_i,
    output logic mode_ready_o,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [`MJSR_BSR_W-1:0] bsr_out_o,
    output logic ring_drive_o,
    output logic ring_hiz_o
);
    localparam int BW = `MJSR_BSR_W;
    localparam int IW = `MJSR_ID_W;
    localparam int MW = `MJSR_MR_W;

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    logic [BW+8:0] sync_q;
    logic tck_d;

    // tck and the tap state lines share one delay, so they stay aligned
    mjsr_sync #(.W(BW + 9)) u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .d_i({ring_i, tck_i, tdi_i, tlr_i, capture_dr_i, shift_dr_i,
              update_dr_i, capture_ir_i, shift_ir_i, update_ir_i}),
        .q_o(sync_q)
    );

    wire [BW-1:0] ring_s = sync_q[BW+8:9];
    wire tck_s = sync_q[8];
    wire tdi_s = sync_q[7];
    wire tlr_s = sync_q[6];
    wire cap_dr_s = sync_q[5];
    wire sh_dr_s = sync_q[4];
    wire upd_dr_s = sync_q[3];
    wire cap_ir_s = sync_q[2];
    wire sh_ir_s = sync_q[1];
    wire upd_ir_s = sync_q[0];

    // edge detection on the sampled test clock
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [`MJSR_IR_W-1:0] instr;
    logic [`MJSR_IR_W-1:0] ir_sh;
    logic [BW-1:0] dr; // see R1
    logic [MW-1:0] mode_register_zero;
    logic [MW-1:0] mode_register_one;
    logic [`MJSR_MR2_W-1:0] mode_register_two;

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    wire op_bsr = (instr == `MJSR_OP_EXTEST) || (instr == `MJSR_OP_SAMPLE); // see R2
    wire op_m01 = (instr == `MJSR_OP_MODE01);
    wire op_m2 = (instr == `MJSR_OP_MODE2);
    wire op_id = (instr == `MJSR_OP_IDCODE) || op_m01 || op_m2; // see R3
    wire op_clamp = (instr == `MJSR_OP_CLAMP);
    wire op_hiz = (instr == `MJSR_OP_HIGHZ);

    // clamp, highz, bypass and any undefined code take the bypass path
    mjsr_pkg::mjsr_path_type path;
    assign path = op_bsr ? mjsr_pkg::mjsr_path_bsr :
                  op_id ? mjsr_pkg::mjsr_path_id :
                  mjsr_pkg::mjsr_path_byp; // see R4 see R5 see R8 see R13

    // ----------------------------------------
    // readout words
    // ----------------------------------------
    wire repair_capable_flag = REPAIR_CAPABLE;
    wire [IW-1:0] id_word = {REVISION, DEVICE_CODE, VENDOR_CODE, 1'b1}; // see R9

    logic [IW-1:0] mode_zero_one_readout;
    logic [IW-1:0] mode_two_readout;

    // gaps read as zero, indicator bit is one
    always_comb begin
        mode_zero_one_readout = '0;
        mode_zero_one_readout[`MJSR_M1_LSB +: MW] = mode_register_one; // see R10
        mode_zero_one_readout[`MJSR_M0_LSB +: MW] = mode_register_zero;
        mode_zero_one_readout[`MJSR_RPR_BIT] = repair_capable_flag; // see R11
        mode_zero_one_readout[0] = 1'b1;
    end

    // undefined upper bits are driven zero for a repeatable readout
    always_comb begin
        mode_two_readout = '0;
        mode_two_readout[`MJSR_M2_LSB +: `MJSR_MR2_W] = mode_register_two; // see R12
        mode_two_readout[0] = 1'b1;
    end

    wire [IW-1:0] id_sel = op_m01 ? mode_zero_one_readout : // see R6
                           op_m2 ? mode_two_readout : // see R7
                           id_word; // see R3

    // ----------------------------------------
    // data register helpers
    // ----------------------------------------
    // one shifter serves all paths; its active length follows the path
    function automatic logic [BW-1:0] shift_in(
        input logic [BW-1:0] d,
        input logic b,
        input mjsr_pkg::mjsr_path_type p
    );
        logic [BW-1:0] r;
        r = d;
        case (p)
            mjsr_pkg::mjsr_path_bsr: r = {b, d[BW-1:1]};
            mjsr_pkg::mjsr_path_id: r = {{(BW-IW){1'b0}}, b, d[IW-1:1]};
            default: r[0] = b;
        endcase
        return r;
    endfunction

    function automatic logic [BW-1:0] capture_val(
        input mjsr_pkg::mjsr_path_type p,
        input logic [BW-1:0] ring,
        input logic [IW-1:0] idw
    );
        logic [BW-1:0] r;
        r = '0;
        case (p)
            mjsr_pkg::mjsr_path_bsr: r = ring;
            mjsr_pkg::mjsr_path_id: r = {{(BW-IW){1'b0}}, idw};
            default: r = '0;
        endcase
        return r;
    endfunction

    wire [BW-1:0] next_dr = cap_dr_s ? capture_val(path, ring_s, id_sel) :
                            shift_in(dr, tdi_s, path);

    // ----------------------------------------
    // mode register queue
    // ----------------------------------------
    logic mq_valid;
    logic [MW+1:0] mq_data;

    // hold the settings still while their readout is being shifted
    wire mq_ready = ~(sh_dr_s & (op_m01 | op_m2));
    wire mq_pop = mq_valid & mq_ready;

    mjsr_fifo #(.W(MW + 2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .in_valid_i(mode_valid_i),
        .in_data_i({mode_sel_i, mode_data_i}),
        .in_ready_o(mode_ready_o),
        .out_valid_o(mq_valid),
        .out_data_o(mq_data),
        .out_ready_i(mq_ready)
    );

    wire [1:0] mq_sel = mq_data[MW+1:MW];

    // latched mode settings as seen by the readout
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_register_zero <= '0;
            mode_register_one <= '0;
            mode_register_two <= '0;
        end else if (mq_pop) begin
            case (mq_sel)
                mjsr_pkg::mjsr_sel_zero: mode_register_zero <= mq_data[MW-1:0];
                mjsr_pkg::mjsr_sel_one: mode_register_one <= mq_data[MW-1:0];
                mjsr_pkg::mjsr_sel_two: mode_register_two <= mq_data[`MJSR_MR2_W-1:0];
                default: mode_register_zero <= mode_register_zero;
            endcase
        end
    end

    // ----------------------------------------
    // instruction register
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            instr <= `MJSR_OP_IDCODE;
            ir_sh <= `MJSR_IR_CAPT;
        end else if (tck_rise) begin
            if (tlr_s) begin
                instr <= `MJSR_OP_IDCODE; // see R15
            end else if (upd_ir_s) begin
                instr <= ir_sh; // see R16
            end
            if (cap_ir_s) begin
                ir_sh <= `MJSR_IR_CAPT;
            end else if (sh_ir_s) begin
                ir_sh <= {tdi_s, ir_sh[`MJSR_IR_W-1:1]}; // see R16
            end
        end
    end

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    // capture and shift on the rising test clock edge
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tck_d <= 1'b0;
            dr <= '0;
        end else begin
            tck_d <= tck_s;
            if (tck_rise && (cap_dr_s || sh_dr_s)) dr <= next_dr; // see R14 see R16
        end
    end

    // update stage feeds the balls under extest and clamp
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bsr_out_o <= '0;
        end else if (tck_rise && upd_dr_s && op_bsr && !tlr_s) begin
            bsr_out_o <= dr; // see R2
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // tdo changes on the falling edge so the tester samples it stable
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o <= sh_ir_s ? ir_sh[0] : dr[0];
            tdo_oe_o <= sh_ir_s | sh_dr_s;
        end
    end

    // ball control follows the active instruction
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ring_drive_o <= 1'b0;
            ring_hiz_o <= 1'b0;
        end else begin
            ring_drive_o <= (instr == `MJSR_OP_EXTEST) | op_clamp; // see R4
            ring_hiz_o <= op_hiz; // see R5
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_cap;
        tck_rise && cap_dr_s;
    endsequence

    sequence s_shift;
        tck_rise && sh_dr_s && !cap_dr_s;
    endsequence

    a_reset_idcode: assert property (tck_rise && tlr_s |=> instr == `MJSR_OP_IDCODE) // see R15
        else $error("reset did not select idcode");
    a_ir_update: assert property (tck_rise && upd_ir_s && !tlr_s
        |=> instr == $past(ir_sh)) // see R16
        else $error("instruction not taken on update");
    a_hiz_ball: assert property (op_hiz |=> ring_hiz_o && !ring_drive_o) // see R5
        else $error("highz not applied");
    a_clamp_ball: assert property (op_clamp |=> ring_drive_o && !ring_hiz_o) // see R4
        else $error("clamp not driving balls");
    a_bsr_capture: assert property (s_cap and op_bsr |=> dr == $past(ring_s)) // see R14
        else $error("ring not captured");
    a_id_capture: assert property (s_cap and (instr == `MJSR_OP_IDCODE)
        |=> dr[IW-1:0] == id_word && dr[0]) // see R9
        else $error("id word wrong");
    a_mode01_cap: assert property (s_cap and op_m01
        |=> dr[31:29] == 3'h0 && dr[16:14] == 3'h0 && dr[13] == REPAIR_CAPABLE) // see R10
        else $error("mode01 readout wrong");
    a_mode2_cap: assert property (s_cap and op_m2
        |=> dr[10:0] == {$past(mode_register_two), 1'b1}) // see R12
        else $error("mode2 readout wrong");
    a_bypass_cap: assert property (s_cap and (path == mjsr_pkg::mjsr_path_byp)
        |=> dr[0] == 1'b0) // see R8
        else $error("bypass capture not zero");
    a_id_shift: assert property (s_shift and (path == mjsr_pkg::mjsr_path_id)
        |=> dr[IW-1] == $past(tdi_s) && dr[IW-2:0] == $past(dr[IW-1:1])) // see R16
        else $error("id path shift wrong");
    a_tdo_fall: assert property (tck_fall && sh_dr_s && !sh_ir_s
        |=> tdo_o == $past(dr[0]) && tdo_oe_o) // see R16
        else $error("tdo not the lsb");
    // all three settings must hold, the queue may only drain outside the readout shift
    a_mode_hold: assert property (sh_dr_s && (op_m01 || op_m2) // see R6
        |=> $stable(mode_register_zero) && $stable(mode_register_one)
            && $stable(mode_register_two))
        else $error("mode settings moved while shifting");
endmodule

// *** bench/mjsr_scan_ctrl.sv ***
// board-side scan controller: owns the test clock and the tap state lines
module mjsr_scan_ctrl (
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tdi_o,
    output logic tlr_o,
    output logic capture_dr_o,
    output logic shift_dr_o,
    output logic update_dr_o,
    output logic capture_ir_o,
    output logic shift_ir_o,
    output logic update_ir_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [134:0] last_out;
    event done;

    // the test clock stands low between frames
    initial begin
        tck_o = 1'h0;
        tdi_o = 1'h0;
        {tlr_o, capture_dr_o, shift_dr_o, update_dr_o, capture_ir_o, shift_ir_o, update_ir_o} = '0;
    end

    // lines move mid-high so they are settled across both edges of the next period
    task automatic tick(input logic [6:0] st, input logic d, input bit drive, output logic q);
        {tlr_o, capture_dr_o, shift_dr_o, update_dr_o, capture_ir_o, shift_ir_o, update_ir_o} = st;
        tdi_o = drive ? d : ~tdi_o; // an idle data line never keeps the old bit
        if (tck_o) begin
            #16;
            tck_o = 1'h0;
        end
        #32;
        tck_o = 1'h1;
        #16;
        q = tdo_oe_i ? tdo_i : 1'hx; // an undriven scan output never counts as data
    endtask

    // one full frame: capture, n shifts lsb first, exit, update, idle
    task automatic scan(input bit ir, input int n, input logic [134:0] din);
        logic q;
        logic [134:0] r;
        r = '0;
        #3;
        tick(ir ? 7'h04 : 7'h20, 1'h0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(ir ? 7'h02 : 7'h10, din[i], 1'b1, q);
            r[i] = q;
        end
        tick(7'h00, 1'h0, 1'b0, q);
        tick(ir ? 7'h01 : 7'h08, 1'h0, 1'b0, q);
        tick(7'h00, 1'h0, 1'b0, q);
        #16;
        tck_o = 1'h0;
        last_out = r;
        -> done;
    endtask

    // two periods in test-logic-reset, then back to idle
    task automatic tap_reset();
        logic q;
        #3;
        tick(7'h40, 1'h0, 1'b0, q);
        tick(7'h40, 1'h0, 1'b0, q);
        tick(7'h00, 1'h0, 1'b0, q);
        #16;
        tck_o = 1'h0;
    endtask
endmodule

// *** bench/test_mjsr_scan_top.sv ***
`include "mjsr_map.svh"

module test_mjsr_scan_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV = 4'h6; // arbitrary value
    localparam logic [15:0] DEV = 16'h1c3e; // arbitrary value
    localparam logic [10:0] VEN = 11'h0d5; // arbitrary value
    localparam logic [31:0] ID_WORD = {REV, DEV, VEN, 1'h1};
    logic clock_i = 1'h0;
    logic nrst_i = 1'h0;
    logic tck, tdi, tlr, cdr, sdr, udr, cir, sir, uir;
    logic [`MJSR_BSR_W-1:0] ring_i = '0;
    logic mode_valid_i = 1'h0;
    logic [1:0] mode_sel_i = 2'h0;
    logic [11:0] mode_data_i = '0;
    logic mode_ready_o, tdo_o, tdo_oe_o, ring_drive_o, ring_hiz_o;
    logic [`MJSR_BSR_W-1:0] bsr_out_o;
    logic [134:0] exp_bsr = '0;
    logic [134:0] q_scan[$];
    logic [136:0] q_pin[$];
    int n_errors = 0;
    int total_checks = 0;
    event pin_ev;

    always #4 clock_i = ~clock_i;

    mjsr_scan_top #(.REVISION(REV), .DEVICE_CODE(DEV), .VENDOR_CODE(VEN),
        .REPAIR_CAPABLE(1'h1), .FIFO_DEPTH(16)) i_mjsr_scan_top (
        .clock_i(clock_i), .nrst_i(nrst_i), .tck_i(tck), .tdi_i(tdi), .tlr_i(tlr),
        .capture_dr_i(cdr), .shift_dr_i(sdr), .update_dr_i(udr), .capture_ir_i(cir),
        .shift_ir_i(sir), .update_ir_i(uir), .ring_i(ring_i), .mode_valid_i(mode_valid_i),
        .mode_sel_i(mode_sel_i), .mode_data_i(mode_data_i), .mode_ready_o(mode_ready_o),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .bsr_out_o(bsr_out_o),
        .ring_drive_o(ring_drive_o), .ring_hiz_o(ring_hiz_o));

    mjsr_scan_ctrl i_mjsr_scan_ctrl (.tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .tck_o(tck),
        .tdi_o(tdi), .tlr_o(tlr), .capture_dr_o(cdr), .shift_dr_o(sdr), .update_dr_o(udr),
        .capture_ir_o(cir), .shift_ir_o(sir), .update_ir_o(uir));

    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_scan(input logic [134:0] e, input logic [134:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_pin(input logic [136:0] e, input logic [136:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    function automatic logic [134:0] rand_w();
        logic [159:0] r;
        r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        return r[134:0];
    endfunction

    // note the expected word, then let the controller run the frame
    task automatic do_scan(input bit ir, input int n, input logic [134:0] din,
                           input logic [134:0] e);
        q_scan.push_back(e);
        @(posedge clock_i);
        i_mjsr_scan_ctrl.scan(ir, n, din);
    endtask

    task automatic load_ir(input logic [7:0] code);
        do_scan(1'b1, 8, 135'(code), 135'(`MJSR_IR_CAPT));
    endtask

    task automatic check_pins(input logic drv, input logic hiz);
        q_pin.push_back({drv, hiz, exp_bsr});
        repeat (3) @(posedge clock_i);
        -> pin_ev;
    endtask

    // one mode word through the buffer; held until ready is seen before an edge
    task automatic mode_word(input logic [1:0] sel, input logic [11:0] d);
        @(posedge clock_i);
        mode_valid_i <= 1'h1;
        mode_sel_i <= sel;
        mode_data_i <= d;
        do @(negedge clock_i); while (mode_ready_o !== 1'h1);
        @(posedge clock_i);
        mode_valid_i <= 1'h0;
    endtask

    // result watchers take the oldest note whenever a result appears
    initial forever begin
        @(i_mjsr_scan_ctrl.done);
        cmp_scan(q_scan.pop_front(), i_mjsr_scan_ctrl.last_out);
    end
    initial forever begin
        @(pin_ev);
        cmp_pin(q_pin.pop_front(), {ring_drive_o, ring_hiz_o, bsr_out_o});
    end

    // watchdog sized well above the ~39 us the sequence needs
    initial begin
        #300us;
        n_errors++;
        print_verdict();
    end

    initial begin
        logic [7:0] codes [4];
        logic [1:0] flags [4];
        logic [134:0] pat, rnd;
        logic [11:0] m0, m1, m2;
        int acc;
        codes = '{`MJSR_OP_BYPASS, `MJSR_OP_CLAMP, `MJSR_OP_HIGHZ, `MJSR_OP_BYPASS};
        flags = '{2'h0, 2'h2, 2'h1, 2'h0};
        acc = 0;
        void'($urandom(93805));
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'h1;
        repeat (2) @(posedge clock_i);
        do_scan(1'b0, 32, rand_w(), 135'(ID_WORD));
        check_pins(1'h0, 1'h0);
        // sample then extest: captured ring out, shifted pattern to the update stage
        for (int i = 0; i < 2; i++) begin
            rnd = rand_w();
            pat = rand_w();
            @(posedge clock_i);
            ring_i <= rnd;
            load_ir(i == 0 ? `MJSR_OP_SAMPLE : `MJSR_OP_EXTEST);
            do_scan(1'b0, 135, pat, rnd);
            exp_bsr = pat;
            check_pins(i == 1, 1'h0);
        end
        // one-bit path codes, defined ones only; the last bypass shows highz released
        for (int i = 0; i < 4; i++) begin
            pat = rand_w();
            load_ir(codes[i]);
            check_pins(flags[i][1], flags[i][0]);
            do_scan(1'b0, 8, pat, 135'({pat[6:0], 1'h0}));
        end
        m0 = 12'($urandom());
        m1 = 12'($urandom());
        m2 = 12'($urandom());
        mode_word(2'h0, m0);
        mode_word(2'h1, m1);
        mode_word(2'h2, m2);
        mode_word(2'h3, ~m0);
        load_ir(`MJSR_OP_MODE01);
        do_scan(1'b0, 32, rand_w(), 135'({3'h0, m1, 3'h0, 1'h1, m0, 1'h1}));
        load_ir(`MJSR_OP_MODE2);
        // buffer fills while a mode readout is shifting, then drains after it
        fork
            do_scan(1'b0, 32, rand_w(), 135'({21'h0, m2[9:0], 1'h1}));
            begin
                wait (sdr === 1'h1);
                repeat (8) @(posedge clock_i);
                mode_sel_i <= 2'h2;
                for (int k = 0; k < 20; k++) begin
                    mode_valid_i <= 1'h1;
                    mode_data_i <= 12'($urandom());
                    @(negedge clock_i);
                    if (mode_ready_o === 1'h1) begin
                        acc++;
                        m2 = mode_data_i;
                    end
                    @(posedge clock_i);
                end
                mode_valid_i <= 1'h0;
            end
        join
        cmp_scan(135'(16), 135'(acc));
        do_scan(1'b0, 32, rand_w(), 135'({21'h0, m2[9:0], 1'h1}));
        i_mjsr_scan_ctrl.tap_reset();
        do_scan(1'b0, 32, rand_w(), 135'(ID_WORD));
        check_pins(1'h0, 1'h0);
        repeat (4) @(posedge clock_i);
        print_verdict();
    end
endmodule
